//--- hdl/dfc_regs.sv
/*
  Diagnostic fault flag register and emitter / clock output control register.
  Assumes a synchronous word register port driven by the serial interface logic,
  fault levels valid when diagnostics_done_pin_in pulses, and one clock with async reset.
*/
`timescale 1ns/1ps
`default_nettype none
module dfc_regs
  import dfc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [dfc_pkg::DFC_ADDR_W-1:0] reg_addr,
  input wire logic [dfc_pkg::DFC_DATA_W-1:0] reg_wdata,
  output logic [dfc_pkg::DFC_DATA_W-1:0] reg_rdata,
  input wire logic diagnostics_done_pin_in,
  input wire logic [dfc_pkg::DFC_FLAG_N-1:0] fault_in,
  output logic diagnostics_done_pin,
  input wire logic serial_data_in,
  output logic serial_data_out_pin,
  output logic serial_data_out_oe,
  output logic divided_clock_output,
  output logic divided_clock_out_oe,
  input wire logic timing_pos_ctrl,
  input wire logic timing_neg_ctrl,
  output logic bridge_pos_drive_pin,
  output logic bridge_neg_drive_pin,
  output logic third_emitter_drive_pin
);
  import dfc_pkg::*;

  // Latched fault flags and the stored control fields
  logic [DFC_FLAG_N-1:0] diagnostic_fault_flags_flags;
  logic third_emitter_select;
  logic serial_out_hiz;
  logic divided_clock_out_hiz;
  logic [DFC_DIV_W-1:0] input_clock_divider_code;
  // Divider state
  // Counter wide enough for the divide-by-12 half period
  logic [DFC_CNT_W-1:0] div_cnt;
  logic div_phase;
  logic [DFC_CNT_W-1:0] half_last;
  genvar gi;

  // Decode; the status address has no write path, so host writes fall away
  // Reads have no side effect on any flag
  wire sel_diagnostic_fault_flags = (reg_addr == DFC_ADDR_W'(DFC_ADDR_DIAGNOSTIC_FAULT_FLAGS));
  wire sel_ctrl = (reg_addr == DFC_ADDR_W'(DFC_ADDR_CTRL));
  wire ctrl_wr = reg_wr & sel_ctrl;

  // Named status fields
  wire powerdown_alarm_flag = diagnostic_fault_flags_flags[DFC_BIT_POWERDOWN_ALARM_FLAG];
  wire emitter_alarm_flag = diagnostic_fault_flags_flags[DFC_BIT_EM_ALM];
  wire emitter_two_open_flag = diagnostic_fault_flags_flags[DFC_BIT_EM2_OPEN];
  wire emitter_one_open_flag = diagnostic_fault_flags_flags[DFC_BIT_EM1_OPEN];
  wire emitter_short_flag = diagnostic_fault_flags_flags[DFC_BIT_EM_SHORT];
  wire neg_output_ground_short_flag = diagnostic_fault_flags_flags[DFC_BIT_NEG_DRIVE_OUTPUT_GND];
  wire pos_output_ground_short_flag = diagnostic_fault_flags_flags[DFC_BIT_POS_DRIVE_OUTPUT_GND];
  wire photodiode_open_flag = diagnostic_fault_flags_flags[DFC_BIT_PD_OPEN];
  wire photodiode_short_flag = diagnostic_fault_flags_flags[DFC_BIT_PD_SHORT];
  wire neg_input_ground_short_flag = diagnostic_fault_flags_flags[DFC_BIT_INN_GND];
  wire pos_input_ground_short_flag = diagnostic_fault_flags_flags[DFC_BIT_INP_GND];
  wire neg_input_emitter_short_flag = diagnostic_fault_flags_flags[DFC_BIT_INN_EM];
  wire pos_input_emitter_short_flag = diagnostic_fault_flags_flags[DFC_BIT_INP_EM];

  // Upper status positions are constant zero
  wire [DFC_DATA_W-1:0] diagnostic_fault_flags_word = {
    {(DFC_DATA_W-DFC_FLAG_N){1'b0}},
    powerdown_alarm_flag,
    emitter_alarm_flag,
    emitter_two_open_flag,
    emitter_one_open_flag,
    emitter_short_flag,
    neg_output_ground_short_flag,
    pos_output_ground_short_flag,
    photodiode_open_flag,
    photodiode_short_flag,
    neg_input_ground_short_flag,
    pos_input_ground_short_flag,
    neg_input_emitter_short_flag,
    pos_input_emitter_short_flag
  };

  // Unused control positions are never stored, so they always read zero
  wire [DFC_DATA_W-1:0] ctrl_word = {
    8'h00,
    third_emitter_select,
    10'h000,
    serial_out_hiz,
    divided_clock_out_hiz,
    input_clock_divider_code
  };

  // Unmapped addresses read zero
  wire [DFC_DATA_W-1:0] next_rdata = sel_diagnostic_fault_flags ? diagnostic_fault_flags_word :
                                     sel_ctrl ? ctrl_word :
                                     '0;

  // Field values taken from a control write
  wire next_third_emitter_select = reg_wdata[DFC_BIT_TX3];
  wire next_serial_out_hiz = reg_wdata[DFC_BIT_SOMI_HIZ];
  wire next_divided_clock_out_hiz = reg_wdata[DFC_BIT_CLK_HIZ];
  wire [DFC_DIV_W-1:0] next_input_clock_divider_code =
    reg_wdata[DFC_DIV_LSB +: DFC_DIV_W];

  // Half period in clocks minus one; unused codes fall back to divide by 2
  always_comb begin
    case (input_clock_divider_code)
      DFC_DIV2: half_last = DFC_HALF_DIV2;
      DFC_DIV4: half_last = DFC_HALF_DIV4;
      DFC_DIV6: half_last = DFC_HALF_DIV6;
      DFC_DIV8: half_last = DFC_HALF_DIV8;
      DFC_DIV12: half_last = DFC_HALF_DIV12;
      // Codes 1 and 6 are not to be used; treat them as divide by 2
      default: half_last = DFC_HALF_DIV2;
    endcase
  end
  // Wrap test uses >= so a code change mid-count cannot overrun
  wire div_by_one = (input_clock_divider_code == DFC_DIV1);
  wire div_wrap = (div_cnt >= half_last);
  wire [DFC_CNT_W-1:0] next_div_cnt = div_wrap ? '0 : div_cnt + 4'h1;
  wire next_div_phase = div_wrap ? ~div_phase : div_phase;

  // Divide by 1 would need the raw clock on a pin; a registered output
  // cannot carry it, so it is approximated by the fastest toggle.
  wire next_divided_clock_output = div_by_one ? ~divided_clock_output : div_phase;
  wire next_divided_clock_out_oe = ~divided_clock_out_hiz;
  wire next_serial_data_out_oe = ~serial_out_hiz;

  // Emitter routing; drive current limit in third-emitter mode is the host's duty
  // Bridge pins stay low while the third emitter owns the controls
  wire next_bridge_pos = third_emitter_select ? 1'b0 : timing_pos_ctrl;
  wire next_bridge_neg = third_emitter_select ? 1'b0 : timing_neg_ctrl;
  wire next_third_emitter = third_emitter_select ? timing_pos_ctrl : 1'b0;

  // Read data is captured, giving a one-cycle read latency
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Control fields load only on a write to the control address
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      third_emitter_select <= DFC_CTRL_RESET[DFC_BIT_TX3];
    end else if (ctrl_wr) begin
      third_emitter_select <= next_third_emitter_select;
    end
  end

  // Serial output three-state field
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_out_hiz <= DFC_CTRL_RESET[DFC_BIT_SOMI_HIZ];
    end else if (ctrl_wr) begin
      serial_out_hiz <= next_serial_out_hiz;
    end
  end

  // Clock output three-state field
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divided_clock_out_hiz <= DFC_CTRL_RESET[DFC_BIT_CLK_HIZ];
    end else if (ctrl_wr) begin
      divided_clock_out_hiz <= next_divided_clock_out_hiz;
    end
  end

  // Divider code field
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      input_clock_divider_code <= DFC_CTRL_RESET[DFC_DIV_LSB +: DFC_DIV_W];
    end else if (ctrl_wr) begin
      input_clock_divider_code <= next_input_clock_divider_code;
    end
  end

  // One flop per flag; each snapshots its fault level at sequence end
  generate
    for (gi = 0; gi < DFC_FLAG_N; gi++) begin : g_flag
      always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          diagnostic_fault_flags_flags[gi] <= DFC_DIAGNOSTIC_FAULT_FLAGS_RESET[gi];
        end else if (diagnostics_done_pin_in) begin
          diagnostic_fault_flags_flags[gi] <= fault_in[gi];
        end
      end
    end
  endgenerate

  // Done pin is a registered copy of the end strobe
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      diagnostics_done_pin <= 1'b0;
    end else begin
      diagnostics_done_pin <= diagnostics_done_pin_in;
    end
  end

  // Divider count restarts at its wrap point
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // Divider phase flips at each wrap
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      div_phase <= 1'b0;
    end else begin
      div_phase <= next_div_phase;
    end
  end

  // Pin drivers; every output leaves a flop
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divided_clock_output <= 1'b0;
    end else begin
      divided_clock_output <= next_divided_clock_output;
    end
  end

  // Clock output enable, low during reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      divided_clock_out_oe <= 1'b0;
    end else begin
      divided_clock_out_oe <= next_divided_clock_out_oe;
    end
  end

  // Serial data output is a plain registered copy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_data_out_pin <= 1'b0;
    end else begin
      serial_data_out_pin <= serial_data_in;
    end
  end

  // Serial output enable, low during reset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_data_out_oe <= 1'b0;
    end else begin
      serial_data_out_oe <= next_serial_data_out_oe;
    end
  end

  // Emitter pins, registered so they share one cycle of lag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bridge_pos_drive_pin <= 1'b0;
    end else begin
      bridge_pos_drive_pin <= next_bridge_pos;
    end
  end

  // Negative bridge pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bridge_neg_drive_pin <= 1'b0;
    end else begin
      bridge_neg_drive_pin <= next_bridge_neg;
    end
  end

  // Third emitter pin
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      third_emitter_drive_pin <= 1'b0;
    end else begin
      third_emitter_drive_pin <= next_third_emitter;
    end
  end
endmodule
`default_nettype wire

//--- hdl/dfc_pkg.sv
/*
  Package for the diagnostic flag and clock output control register pair.
  Assumes a single 40 MHz clock domain and a word-wide register access port.
*/
package dfc_pkg;
  localparam int unsigned DFC_DATA_W = 24;
  localparam int unsigned DFC_ADDR_W = 8;
  localparam int unsigned DFC_FLAG_N = 13;
  localparam logic [7:0] DFC_ADDR_DIAGNOSTIC_FAULT_FLAGS = 8'h30;
  localparam logic [7:0] DFC_ADDR_CTRL = 8'h31;
  localparam logic [23:0] DFC_DIAGNOSTIC_FAULT_FLAGS_RESET = 24'h000000;
  localparam logic [23:0] DFC_CTRL_RESET = 24'h000000;
  // Field positions
  localparam int unsigned DFC_BIT_POWERDOWN_ALARM_FLAG = 12;
  localparam int unsigned DFC_BIT_EM_ALM = 11;
  localparam int unsigned DFC_BIT_EM2_OPEN = 10;
  localparam int unsigned DFC_BIT_EM1_OPEN = 9;
  localparam int unsigned DFC_BIT_EM_SHORT = 8;
  localparam int unsigned DFC_BIT_NEG_DRIVE_OUTPUT_GND = 7;
  localparam int unsigned DFC_BIT_POS_DRIVE_OUTPUT_GND = 6;
  localparam int unsigned DFC_BIT_PD_OPEN = 5;
  localparam int unsigned DFC_BIT_PD_SHORT = 4;
  localparam int unsigned DFC_BIT_INN_GND = 3;
  localparam int unsigned DFC_BIT_INP_GND = 2;
  localparam int unsigned DFC_BIT_INN_EM = 1;
  localparam int unsigned DFC_BIT_INP_EM = 0;
  localparam int unsigned DFC_BIT_TX3 = 15;
  localparam int unsigned DFC_BIT_SOMI_HIZ = 4;
  localparam int unsigned DFC_BIT_CLK_HIZ = 3;
  localparam int unsigned DFC_DIV_LSB = 0;
  localparam int unsigned DFC_DIV_W = 3;
  // Writable control bits: 15, 4, 3, 2:0
  localparam logic [23:0] DFC_CTRL_MASK = 24'h00801f;
  // Divider codes
  localparam logic [2:0] DFC_DIV2 = 3'h0;
  localparam logic [2:0] DFC_DIV4 = 3'h2;
  localparam logic [2:0] DFC_DIV6 = 3'h3;
  localparam logic [2:0] DFC_DIV8 = 3'h4;
  localparam logic [2:0] DFC_DIV12 = 3'h5;
  localparam logic [2:0] DFC_DIV1 = 3'h7;
  // Half period minus one, in clocks, per divider code
  localparam logic [3:0] DFC_HALF_DIV2 = 4'h0;
  localparam logic [3:0] DFC_HALF_DIV4 = 4'h1;
  localparam logic [3:0] DFC_HALF_DIV6 = 4'h2;
  localparam logic [3:0] DFC_HALF_DIV8 = 4'h3;
  localparam logic [3:0] DFC_HALF_DIV12 = 4'h5;
  localparam int unsigned DFC_CNT_W = 4;
endpackage

//--- bench/dfc_checker.sv
/* Checker of the flag and control registers.
   Assumes a bind onto dfc_regs and one clock. */
`timescale 1ns/1ps
`default_nettype none
module dfc_checker(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic [23:0] reg_rdata,
  input wire logic diagnostics_done_pin_in,
  input wire logic [12:0] fault_in,
  input wire logic diagnostics_done_pin,
  input wire logic serial_data_out_oe,
  input wire logic timing_pos_ctrl,
  input wire logic bridge_pos_drive_pin,
  input wire logic third_emitter_drive_pin
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire rs = reg_rd && reg_addr == 8'h30 && !diagnostics_done_pin_in;
  wire wc = reg_wr && reg_addr == 8'h31;
  a_done_lag: assert property (diagnostics_done_pin == $past(diagnostics_done_pin_in)) else $error("done");
  a_status_top: assert property (rs |=> reg_rdata[23:13] == 11'h0) else $error("top");
  a_flag_latch: assert property (diagnostics_done_pin_in ##1 rs |=> reg_rdata[12:0] == $past(fault_in, 2))
    else $error("latch");
  a_flag_hold: assert property (rs ##1 rs |=> $stable(reg_rdata)) else $error("hold");
  a_somi_hiz: assert property (wc |=> ##1 serial_data_out_oe == !$past(reg_wdata[4], 2))
    else $error("somi");
  a_ctrl_back: assert property (wc ##1 (reg_rd && !reg_wr && reg_addr == 8'h31)
    |=> reg_rdata == ($past(reg_wdata, 2) & 24'h00801f)) else $error("ctrl");
  a_third_route: assert property (wc && reg_wdata[15] ##1 !reg_wr
    |=> third_emitter_drive_pin == $past(timing_pos_ctrl) && !bridge_pos_drive_pin) else $error("tx3");
  a_bridge_route: assert property (wc && !reg_wdata[15] ##1 !reg_wr
    |=> bridge_pos_drive_pin == $past(timing_pos_ctrl) && !third_emitter_drive_pin) else $error("brg");
endmodule
`default_nettype wire

//--- bench/dfc_host.sv
/* Host model on the register port.
   Assumes the bench calls its tasks; drives on falling edges. */
`timescale 1ns/1ps
`default_nettype none
module dfc_host(
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [23:0] reg_wdata
);
  initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
  // Strobes held between calls so accesses go back to back
  task automatic acc(input logic w, input logic [7:0] a, input logic [23:0] d);
    @(negedge clk);
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
  endtask
  task automatic idle();
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  endtask
  // Release serial output when done, reserved bits zero, no current setting
  task automatic park();
    acc(1'b1, 8'h31, 24'h000010);
    idle();
  endtask
endmodule
`default_nettype wire

//--- bench/tb_diagnostic_fault_flags_flags_and_clock_control_regs.sv
/* Bench of the flag and control registers.
   Assumes dfc_regs, dfc_host and dfc_checker compiled first. */
`timescale 1ns/1ps
`default_nettype none
module tb_diagnostic_fault_flags_flags_and_clock_control_regs;
  import dfc_pkg::*;
  logic clk, reset_n, diagnostics_done_pin_in, sdi, tpos, tneg, reg_wr, reg_rd;
  logic done, sdo, sdo_oe, dco, dco_oe, bp, bn, tx3;
  logic [7:0] reg_addr;
  logic [23:0] reg_wdata, reg_rdata;
  logic [12:0] fault_in;
  int err_total = 0;
  int total_checks = 0;
  int hp[8] = '{1, 1, 2, 3, 4, 6, 1, 1};
  dfc_host host_u(.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  dfc_regs dut_u(.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .diagnostics_done_pin_in(diagnostics_done_pin_in),
    .fault_in(fault_in), .diagnostics_done_pin(done), .serial_data_in(sdi),
    .serial_data_out_pin(sdo), .serial_data_out_oe(sdo_oe), .divided_clock_output(dco),
    .divided_clock_out_oe(dco_oe), .timing_pos_ctrl(tpos), .timing_neg_ctrl(tneg),
    .bridge_pos_drive_pin(bp), .bridge_neg_drive_pin(bn), .third_emitter_drive_pin(tx3));
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] exp);
    host_u.acc(1'b0, a, 24'h0);
    host_u.idle();
    chk(reg_rdata, exp);
  endtask
  // First full half period, between the first two toggles; the part before the first may be cut short
  task automatic half(input int h);
    logic p;
    int t, n, m;
    p = dco;
    t = 0;
    n = 0;
    m = 0;
    repeat (40) begin
      @(negedge clk);
      n++;
      if (dco !== p) begin
        t++;
        if (t == 2) m = n;
        n = 0;
      end
      p = dco;
    end
    chk(m, h);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    tally_and_finish();
  end
  initial begin
    {reset_n, diagnostics_done_pin_in, sdi, tpos, tneg, fault_in} = '0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    rd(8'h30, 24'h0);
    rd(8'h31, 24'h0);
    chk({sdo_oe, dco_oe}, 2'b11);
    foreach (hp[i]) begin
      host_u.acc(1'b1, 8'h31, 24'(i));
      rd(8'h31, 24'(i));
      half(hp[i]);
    end
    host_u.acc(1'b1, 8'h31, 24'hffffff);
    rd(8'h31, DFC_CTRL_MASK);
    chk({sdo_oe, dco_oe}, 2'b00);
    for (int i = 0; i < 13; i++) begin
      host_u.acc(1'b1, 8'h30, 24'hffffff);
      fault_in = 13'h1 << i;
      diagnostics_done_pin_in = 1'b1;
      host_u.acc(1'b0, 8'h30, 24'h0);
      diagnostics_done_pin_in = 1'b0;
      fault_in = ~fault_in;
      chk(done, 1'b1);
      host_u.idle();
      chk(reg_rdata, 24'h1 << i);
      chk(done, 1'b0);
    end
    host_u.acc(1'b0, 8'h30, 24'h0);
    host_u.acc(1'b0, 8'h30, 24'h0);
    host_u.idle();
    chk(reg_rdata, 24'h001000);
    host_u.acc(1'b1, 8'h31, 24'h0);
    {tpos, tneg, sdi} = 3'b111;
    repeat (2) @(negedge clk);
    chk({bp, bn, tx3, sdo}, 4'b1101);
    host_u.acc(1'b1, 8'h31, 24'h008000);
    host_u.idle();
    @(negedge clk);
    chk({bp, bn, tx3}, 3'b001);
    host_u.park();
    @(negedge clk);
    chk(sdo_oe, 1'b0);
    tally_and_finish();
  end
endmodule
bind dfc_regs dfc_checker chk_u(.clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .diagnostics_done_pin_in(diagnostics_done_pin_in),
  .fault_in(fault_in), .diagnostics_done_pin(diagnostics_done_pin),
  .serial_data_out_oe(serial_data_out_oe), .timing_pos_ctrl(timing_pos_ctrl),
  .bridge_pos_drive_pin(bridge_pos_drive_pin), .third_emitter_drive_pin(third_emitter_drive_pin));
`default_nettype wire
